// file: logic/sfs_frame_ctrl.sv
// frame-sync and select control with ahb-lite register slave
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
module sfs_frame_ctrl (
    // system clock and reset
    input  wire logic                         CLOCK,
    input  wire logic                         RST_N,
    // ahb-lite slave
    input  wire logic                         HSEL,
    input  wire logic [sfs_pkg::SFS_ADDR_W-1:0] HADDR,
    input  wire logic [1:0]                   HTRANS,
    input  wire logic                         HWRITE,
    input  wire logic [2:0]                   HSIZE,
    input  wire logic [31:0]                  HWDATA,
    input  wire logic                         HREADY,
    output logic      [31:0]                  HRDATA,
    output logic                              HREADYOUT,
    output logic                              HRESP,
    // serial link clock
    input  wire logic                         SCK_LINK,
    // frame pulse pin
    input  wire logic                         FRAME_I,
    output logic                              FRAME_O,
    output logic                              FRAME_OE,
    // select line pin
    output logic                              SEL_O,
    output logic                              SEL_OE,
    // effective audio settings to the data path
    output logic                              AUD_MONO,
    output logic [sfs_pkg::SFS_FMT_W-1:0]     AUD_FMT,
    output logic                              URD_TX_EN
);
    import sfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // bus side registers
    logic [15:0]           ctrl_reg;
    logic                  port_en_reg;
    logic                  audio_protocol_enable_reg;
    logic                  mono_reg;
    logic                  ignore_transmit_underrun_reg;
    logic                  underrun_data_transmit_enable_reg;
    logic [SFS_FMT_W-1:0]  fmt_reg;
    logic [SFS_WL_W-1:0]   wl_reg;
    logic [SFS_FCNT_W-1:0] fcnt_reg;
    logic                  wr_pend_reg;
    logic [SFS_ADDR_W-1:0] wr_addr_reg;
    logic                  width_eff;
    logic                  frame_tgl_b;
    logic                  frame_tgl_d_reg;
    logic                  sel_act_b;
    logic [31:0]           rdata_next;
    logic                  acc_valid;

    // pulse width forced wide outside pcm/dsp while the audio protocol is enabled
    assign width_eff = ctrl_reg[SFS_WIDTH_BIT] |
                       (audio_protocol_enable_reg && fmt_reg != SFS_FMT_PCM);
    assign acc_valid = HSEL && HREADY && HTRANS == SFS_HTRANS_NONSEQ;

    // address phase capture; zero-wait answers
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            HREADYOUT   <= 1'b1;
            HRESP       <= SFS_HRESP_OKAY;
        end else begin
            wr_pend_reg <= acc_valid && HWRITE;
            wr_addr_reg <= HADDR;
            HREADYOUT   <= 1'b1;
            HRESP       <= SFS_HRESP_OKAY;
        end
    end

    // read mux, unmapped reads as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (HADDR == SFS_CTRL_OFS) begin
            rdata_next[15:0] = ctrl_reg;
        end else if (HADDR == SFS_AUDIO_OFS) begin
            rdata_next[SFS_EN_BIT]     = port_en_reg;
            rdata_next[SFS_AUDIO_PROTOCOL_ENABLE_BIT]  = audio_protocol_enable_reg;
            rdata_next[SFS_MONO_BIT]   = mono_reg;
            rdata_next[SFS_IGNORE_TRANSMIT_UNDERRUN_BIT] = ignore_transmit_underrun_reg;
            rdata_next[SFS_UNDERRUN_DATA_TRANSMIT_ENABLE_BIT] = underrun_data_transmit_enable_reg;
            rdata_next[SFS_FMT_LSB +: SFS_FMT_W] = fmt_reg;
            rdata_next[SFS_WL_LSB +: SFS_WL_W]   = wl_reg;
        end else if (HADDR == SFS_STATUS_OFS) begin
            rdata_next[SFS_FCNT_LSB +: SFS_FCNT_W] = fcnt_reg;
            rdata_next[SFS_SEL_BIT]  = sel_act_b;
            rdata_next[SFS_WEFF_BIT] = width_eff;
            rdata_next[SFS_MEFF_BIT] = AUD_MONO;
            rdata_next[SFS_UEFF_BIT] = URD_TX_EN;
        end
    end

    // read data sampled in the address phase
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            HRDATA <= 32'h0000_0000;
        end else if (acc_valid && !HWRITE) begin
            HRDATA <= rdata_next;
        end
    end

    // control register: frame settings
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= 16'h0000;
        end else if (wr_pend_reg && wr_addr_reg == SFS_CTRL_OFS) begin
            ctrl_reg <= HWDATA[15:0] & SFS_CTRL_MASK;
        end
    end

    // audio register: some fields lock while the port runs
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            port_en_reg <= 1'b0;
            audio_protocol_enable_reg   <= 1'b0;
            mono_reg    <= 1'b0;
            ignore_transmit_underrun_reg  <= 1'b0;
            underrun_data_transmit_enable_reg  <= 1'b0;
            fmt_reg     <= '0;
            wl_reg      <= '0;
        end else if (wr_pend_reg && wr_addr_reg == SFS_AUDIO_OFS) begin
            port_en_reg <= HWDATA[SFS_EN_BIT];
            ignore_transmit_underrun_reg  <= HWDATA[SFS_IGNORE_TRANSMIT_UNDERRUN_BIT];
            underrun_data_transmit_enable_reg  <= HWDATA[SFS_UNDERRUN_DATA_TRANSMIT_ENABLE_BIT];
            wl_reg      <= HWDATA[SFS_WL_LSB +: SFS_WL_W];
            if (!port_en_reg) begin
                audio_protocol_enable_reg <= HWDATA[SFS_AUDIO_PROTOCOL_ENABLE_BIT];
                mono_reg  <= HWDATA[SFS_MONO_BIT];
                fmt_reg   <= HWDATA[SFS_FMT_LSB +: SFS_FMT_W];
            end
        end
    end

    // effective audio settings, gated by their enabling bits
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            AUD_MONO  <= 1'b0;
            AUD_FMT   <= '0;
            URD_TX_EN <= 1'b0;
        end else begin
            AUD_MONO  <= mono_reg & audio_protocol_enable_reg;
            AUD_FMT   <= audio_protocol_enable_reg ? fmt_reg : '0;
            URD_TX_EN <= underrun_data_transmit_enable_reg & ignore_transmit_underrun_reg;
        end
    end

    // frame pulse counter fed by a toggle from the link side
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            frame_tgl_d_reg <= 1'b0;
            fcnt_reg        <= '0;
        end else begin
            frame_tgl_d_reg <= frame_tgl_b;
            if (frame_tgl_b != frame_tgl_d_reg) begin
                fcnt_reg <= fcnt_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link side: reset, configuration crossing, frame input
    localparam int CFG_W = 6 + SFS_FMT_W + SFS_CNT_W + SFS_WL_W;
    logic                  rst_l_n;
    logic                  rst_meta_reg;
    logic [CFG_W-1:0]      cfg_l;
    logic                  en_l;
    logic                  en_q;
    logic                  en_hold_reg;
    logic                  dir_l;
    logic                  pol_l;
    logic                  master_select_auto_enable_l;
    logic                  width_bit_l;
    logic                  audio_protocol_enable_l;
    logic [SFS_FMT_W-1:0]  fmt_l;
    logic                  width_l;
    logic [SFS_CNT_W-1:0]  cnt_l;
    logic [SFS_WL_W-1:0]   wl_l;
    logic                  frame_in_l;
    logic                  frame_in_d_reg;
    logic                  fr_edge;
    logic [1:0]            back_b;

    // async assert, clocked release in the link domain
    always_ff @(posedge SCK_LINK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_reg <= 1'b0;
            rst_l_n      <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_l_n      <= rst_meta_reg;
        end
    end

    // settings are quasi-static while the port runs
    sfs_sync #(.W(CFG_W)) u_cfg_sync (
        .clk   (SCK_LINK),
        .rst_n (rst_l_n),
        .d     ({port_en_reg, ctrl_reg[SFS_DIR_BIT], ctrl_reg[SFS_POL_BIT],
                 ctrl_reg[SFS_MASTER_SELECT_AUTO_ENABLE_BIT], ctrl_reg[SFS_WIDTH_BIT], audio_protocol_enable_reg, fmt_reg,
                 ctrl_reg[SFS_CNT_LSB +: SFS_CNT_W], wl_reg}),
        .q     (cfg_l)
    );
    assign {en_q, dir_l, pol_l, master_select_auto_enable_l, width_bit_l, audio_protocol_enable_l, fmt_l, cnt_l, wl_l} = cfg_l;
    // raw bits cross, so no combinational glitch reaches the synchroniser
    assign width_l = width_bit_l | (audio_protocol_enable_l && fmt_l != SFS_FMT_PCM);
    // enable trails the settings by a link clock, so a bit that settles late is in place
    assign en_l    = en_q && en_hold_reg;

    // frame pin from the peer passes two flops
    sfs_sync #(.W(1)) u_frame_sync (
        .clk   (SCK_LINK),
        .rst_n (rst_l_n),
        .d     (FRAME_I),
        .q     (frame_in_l)
    );

    // asserted edge of the incoming pulse in its own polarity
    always_ff @(posedge SCK_LINK or negedge rst_l_n) begin
        if (!rst_l_n) begin
            frame_in_d_reg <= 1'b1; // seen as asserted, so release gives no false edge
        end else begin
            frame_in_d_reg <= frame_in_l ~^ pol_l;
        end
    end
    assign fr_edge = (frame_in_l ~^ pol_l) && !frame_in_d_reg;

    ////////////////////////////////////////////////////////////////////////////
    // link side: bit and word counting, pulse and select generation
    logic [SFS_WL_W-1:0]   bit_cnt_reg;
    logic [SFS_WL_W-1:0]   bit_cnt_next;
    logic [SFS_WCNT_W-1:0] word_cnt_reg;
    logic [SFS_WCNT_W-1:0] word_cnt_next;
    logic [SFS_WCNT_W-1:0] word_lim;
    logic                  run_reg;
    logic                  run_next;
    logic                  frame_act_reg;
    logic                  frame_act_next;
    logic                  sel_act_reg;
    logic                  frame_tgl_reg;

    // reserved codes clamp to the longest legal group
    assign word_lim = (SFS_WCNT_W'(1) << ((cnt_l > SFS_CNT_MAX) ? SFS_CNT_MAX : cnt_l))
                      - SFS_WCNT_W'(1);

    // next-state of the counters
    always_comb begin
        run_next      = run_reg;
        bit_cnt_next  = bit_cnt_reg;
        word_cnt_next = word_cnt_reg;
        if (!en_l) begin
            run_next      = 1'b0;
            bit_cnt_next  = '0;
            word_cnt_next = '0;
        end else if (dir_l && fr_edge) begin
            run_next      = 1'b1;
            bit_cnt_next  = '0;
            word_cnt_next = '0;
        end else if (!dir_l && !run_reg) begin
            run_next      = 1'b1;
        end else if (run_reg) begin
            if (bit_cnt_reg == wl_l) begin
                bit_cnt_next  = '0;
                word_cnt_next = (word_cnt_reg >= word_lim) ? '0 : word_cnt_reg + 1'b1;
            end else begin
                bit_cnt_next  = bit_cnt_reg + 1'b1;
            end
        end
        // one clock at the start of the group's first word, or that whole first word
        frame_act_next = en_l && !dir_l && run_next && word_cnt_next == '0 &&
                         (width_l || bit_cnt_next == '0);
    end

    // counters and run state
    always_ff @(posedge SCK_LINK or negedge rst_l_n) begin
        if (!rst_l_n) begin
            run_reg      <= 1'b0;
            en_hold_reg  <= 1'b0;
            bit_cnt_reg  <= '0;
            word_cnt_reg <= '0;
        end else begin
            run_reg      <= run_next;
            en_hold_reg  <= en_q;
            bit_cnt_reg  <= bit_cnt_next;
            word_cnt_reg <= word_cnt_next;
        end
    end

    // frame pulse pin, driven only as master
    always_ff @(posedge SCK_LINK or negedge rst_l_n) begin
        if (!rst_l_n) begin
            frame_act_reg <= 1'b0;
            FRAME_O       <= 1'b0;
            FRAME_OE      <= 1'b0;
            frame_tgl_reg <= 1'b0;
        end else begin
            frame_act_reg <= frame_act_next;
            FRAME_O       <= frame_act_next ? pol_l : ~pol_l;
            FRAME_OE      <= !dir_l;
            if ((frame_act_next && !frame_act_reg) || (dir_l && en_l && fr_edge)) begin
                frame_tgl_reg <= ~frame_tgl_reg;
            end
        end
    end

    // select line, released to pin logic unless auto-driven
    always_ff @(posedge SCK_LINK or negedge rst_l_n) begin
        if (!rst_l_n) begin
            sel_act_reg <= 1'b0;
            SEL_O       <= 1'b0;
            SEL_OE      <= 1'b0;
        end else begin
            sel_act_reg <= en_l && !dir_l && master_select_auto_enable_l && run_next;
            SEL_O       <= (en_l && !dir_l && master_select_auto_enable_l && run_next) ? pol_l : ~pol_l;
            SEL_OE      <= !dir_l && master_select_auto_enable_l;
        end
    end

    // link state back to the bus domain
    sfs_sync #(.W(2)) u_back_sync (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .d     ({frame_tgl_reg, sel_act_reg}),
        .q     (back_b)
    );
    assign {frame_tgl_b, sel_act_b} = back_b;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    audlock_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        wr_pend_reg && port_en_reg |=> $stable(audio_protocol_enable_reg))
        else $error("audio enable changed while port enabled");
    monofmt_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        port_en_reg && $past(port_en_reg) |-> $stable(fmt_reg) && $stable(mono_reg))
        else $error("audio format or mono changed while port enabled");
    mono_eff_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !audio_protocol_enable_reg ##1 !audio_protocol_enable_reg |-> !AUD_MONO)
        else $error("mono active without audio enable");
    urd_eff_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !ignore_transmit_underrun_reg |=> !URD_TX_EN)
        else $error("underrun transmit active without ignore");
    wide_force_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        audio_protocol_enable_reg && fmt_reg != SFS_FMT_PCM |-> width_eff)
        else $error("non-pcm format without word-wide pulse");
    frame_dir_a: assert property (@(posedge SCK_LINK) disable iff (!rst_l_n)
        dir_l ##1 dir_l |-> !FRAME_OE && !frame_act_reg)
        else $error("frame pin driven in slave role");
    frame_pol_a: assert property (@(posedge SCK_LINK) disable iff (!rst_l_n)
        $stable(pol_l) && $past(rst_l_n) |-> // pin still at reset level just after release
        FRAME_O == (frame_act_reg ? $past(pol_l) : ~$past(pol_l)))
        else $error("frame level does not follow polarity");
    pulse_one_a: assert property (@(posedge SCK_LINK) disable iff (!rst_l_n)
        $rose(frame_act_reg) && !width_l && wl_l != '0 && $stable(width_l) |=> !frame_act_reg)
        else $error("narrow frame pulse longer than one clock");
    pulse_word_a: assert property (@(posedge SCK_LINK) disable iff (!rst_l_n)
        frame_act_reg && width_l && en_l && bit_cnt_reg != wl_l |=> frame_act_reg || !en_l)
        else $error("wide frame pulse ended inside its word");
    word_lim_a: assert property (@(posedge SCK_LINK) disable iff (!rst_l_n)
        $stable(cnt_l) && $past(word_cnt_reg) <= word_lim |-> word_cnt_reg <= word_lim)
        else $error("word counter passed its group size");
    sel_drive_a: assert property (@(posedge SCK_LINK) disable iff (!rst_l_n)
        en_l && !dir_l && master_select_auto_enable_l && run_reg |=> SEL_OE && sel_act_reg)
        else $error("select not driven in master transfer");
    sel_off_a: assert property (@(posedge SCK_LINK) disable iff (!rst_l_n)
        !master_select_auto_enable_l |=> !SEL_OE)
        else $error("select driven with auto-enable clear");
    cnt_clear_a: assert property (@(posedge SCK_LINK) disable iff (!rst_l_n)
        !en_l |=> word_cnt_reg == '0 && bit_cnt_reg == '0)
        else $error("word counter not cleared while disabled");
endmodule // sfs_frame_ctrl

// file: logic/sfs_pkg.sv
// shared constants for the frame-sync and select control block
package sfs_pkg;
    // register byte offsets
    localparam logic [7:0] SFS_CTRL_OFS   = 8'h00;
    localparam logic [7:0] SFS_AUDIO_OFS  = 8'h04;
    localparam logic [7:0] SFS_STATUS_OFS = 8'h08;
    localparam int         SFS_ADDR_W     = 8;
    // control register fields
    localparam int SFS_DIR_BIT   = 6;
    localparam int SFS_POL_BIT   = 5;
    localparam int SFS_MASTER_SELECT_AUTO_ENABLE_BIT = 4;
    localparam int SFS_WIDTH_BIT = 3;
    localparam int SFS_CNT_LSB   = 0;
    localparam int SFS_CNT_W     = 3;
    localparam logic [15:0] SFS_CTRL_MASK = 16'h007f;
    // audio/enable register fields
    localparam int SFS_EN_BIT     = 0;
    localparam int SFS_AUDIO_PROTOCOL_ENABLE_BIT  = 1;
    localparam int SFS_MONO_BIT   = 2;
    localparam int SFS_IGNORE_TRANSMIT_UNDERRUN_BIT = 3;
    localparam int SFS_UNDERRUN_DATA_TRANSMIT_ENABLE_BIT = 4;
    localparam int SFS_FMT_LSB    = 5;
    localparam int SFS_FMT_W      = 2;
    localparam int SFS_WL_LSB     = 8;
    localparam int SFS_WL_W       = 5;
    // status register fields
    localparam int SFS_FCNT_LSB   = 0;
    localparam int SFS_FCNT_W     = 8;
    localparam int SFS_SEL_BIT    = 8;
    localparam int SFS_WEFF_BIT   = 9;
    localparam int SFS_MEFF_BIT   = 10;
    localparam int SFS_UEFF_BIT   = 11;
    // audio format that keeps the pulse width bit honoured
    localparam logic [1:0] SFS_FMT_PCM   = 2'h3;
    // largest legal words-per-pulse code (32 words)
    localparam logic [2:0] SFS_CNT_MAX   = 3'h5;
    localparam int         SFS_WCNT_W    = 6;
    // ahb encodings
    localparam logic [1:0] SFS_HTRANS_NONSEQ = 2'h2;
    localparam logic       SFS_HRESP_OKAY    = 1'b0;
endpackage

// file: logic/sfs_sync.sv
// two-flop synchroniser for levels and quasi-static buses
`timescale 1ns/10ps
module sfs_sync #(
    parameter int W = 1
) (
    // destination clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // sfs_sync

// file: tb/sfs_peer_model.sv
// serial peer model that sends frame pulses toward a port in slave role
`timescale 1ns/10ps
module sfs_peer_model (
    // link clock
    input  wire logic       sck,
    // pulse control from the bench
    input  wire logic       run,
    input  wire logic       pol,
    input  wire logic [7:0] gap,
    // frame pulse line and pulses sent so far
    output logic            frame,
    output logic [7:0]      sent
);
    logic [7:0] cnt_reg;
    // idle inactive from time zero so the port never sees a false edge
    initial begin
        cnt_reg = 8'h00;
        sent    = 8'h00;
        frame   = 1'b0;
    end
    // one-clock pulse at the shared asserted level every gap link clocks
    always @(posedge sck) begin
        if (!run) begin
            cnt_reg <= 8'h00;
            frame   <= ~pol;
        end else if (cnt_reg == gap - 8'h01) begin
            cnt_reg <= 8'h00;
            frame   <= pol;
            sent    <= sent + 8'h01;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            frame   <= ~pol;
        end
    end
endmodule // sfs_peer_model

// file: tb/tb_sfs_frame_ctrl.sv
// self-checking bench for the frame-sync and select control block
`timescale 1ns/10ps
module tb_sfs_frame_ctrl;
    import sfs_pkg::*;
    // word length 4 link clocks, port enabled
    localparam logic [31:0] EN_WL = 32'h0000_0301;
    logic        clock, rst_n, sck, hsel, hwrite, hready, run, pol_p, pl;
    logic [7:0]  haddr, gap, sent, b, d;
    logic [1:0]  htrans, aud_fmt;
    logic [31:0] hwdata, hrdata, rd, aud;
    logic        hreadyout, hresp, frame_i, frame_o, frame_oe;
    logic        sel_o, sel_oe, aud_mono, urd_tx_en;
    int          err_count, n_compared, w, p, k;

    sfs_frame_ctrl sfs_frame_ctrl_inst (
        .CLOCK(clock), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SCK_LINK(sck),
        .FRAME_I(frame_i), .FRAME_O(frame_o), .FRAME_OE(frame_oe), .SEL_O(sel_o),
        .SEL_OE(sel_oe), .AUD_MONO(aud_mono), .AUD_FMT(aud_fmt), .URD_TX_EN(urd_tx_en)
    );
    sfs_peer_model sfs_peer_model_inst (
        .sck(sck), .run(run), .pol(pol_p), .gap(gap), .frame(frame_i), .sent(sent)
    );

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;
    // system clock and an unrelated link clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        sck = 1'b0;
        #3;
        forever #7.5 sck = ~sck;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            err_count++;
            $display("mismatch at %0t: wait ran out", $time);
            tally_and_finish;
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished, %0d mismatches so far", s, err_count);
    endtask
    // bus cycle: hold each phase until ready is sampled high
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hready !== 1'b1 && n < 50);
        tmo(n, 50);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        htrans <= SFS_HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        rd = hrdata;
    endtask
    // settings change only while the port is disabled
    task automatic setup(input logic [31:0] ctrl, input logic [31:0] a);
        bus(1'b1, SFS_AUDIO_OFS, 32'h0);
        bus(1'b1, SFS_CTRL_OFS, ctrl);
        bus(1'b1, SFS_AUDIO_OFS, a);
        repeat (3) @(posedge clock);
    endtask
    function automatic logic [31:0] ctl(input logic dr, input logic po, input logic ms,
                                        input logic wd, input logic [2:0] c);
        return {25'h0, dr, po, ms, wd, c};
    endfunction
    // counts link clocks until the frame output shows the given level
    task automatic edge_wait(input logic lvl, inout int n);
        int j;
        j = 0;
        while (frame_o !== lvl && j < 400) begin
            @(negedge sck);
            j++;
        end
        tmo(j, 400);
        n = n + j;
    endtask
    // width and start-to-start spacing of the next whole pulse
    task automatic measure(input logic lvl);
        w = 0;
        edge_wait(~lvl, w);
        edge_wait(lvl, w);
        w = 0;
        edge_wait(~lvl, w);
        p = w;
        edge_wait(lvl, p);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // hang guard
    initial begin
        #3000000;
        tmo(1, 1);
    end
    // main sequence
    initial begin
        rst_n = 1'b0; hsel = 1'b1; htrans = 2'h0; haddr = 8'h00; hwrite = 1'b0;
        hwdata = 32'h0; run = 1'b0; pol_p = 1'b1; gap = 8'h08;
        err_count = 0; n_compared = 0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        check({hreadyout, hresp, frame_oe, sel_oe}, 32'h8);
        // reset contents, unmapped place reads zero, control field mask
        for (int a = 0; a < 16; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            check(rd, 32'h0);
        end
        bus(1'b1, SFS_CTRL_OFS, 32'hffff);
        bus(1'b0, SFS_CTRL_OFS, 32'h0);
        check(rd, 32'h7f);
        done("registers");
        // master pulses for every legal count code, both polarities
        for (int c = 0; c < 6; c++) begin
            pl = c[0];
            setup(ctl(1'b0, pl, 1'b1, 1'b0, 3'(c)), EN_WL);
            measure(pl);
            check(w, 1);
            check(p, 4 << c);
            check({frame_oe, sel_oe, sel_o}, {2'b11, pl});
        end
        // disabling mid-run restarts the word count
        bus(1'b1, SFS_AUDIO_OFS, 32'h0);
        bus(1'b1, SFS_AUDIO_OFS, EN_WL);
        k = 0;
        edge_wait(1'b1, k);
        check(32'(k < 12), 1);
        done("master");
        // word-wide pulses by the width bit and by non-pcm formats
        setup(ctl(1'b0, 1'b1, 1'b1, 1'b1, 3'h1), EN_WL);
        measure(1'b1);
        check(w, 4);
        check(p, 8);
        for (int f = 0; f < 5; f++) begin
            aud = (f < 4) ? (EN_WL | 32'h2 | 32'(f << 5)) : EN_WL;
            setup(ctl(1'b0, 1'b1, 1'b1, 1'b0, 3'h1), aud);
            measure(1'b1);
            check(w, (f < 4 && f != int'(SFS_FMT_PCM)) ? 4 : 1);
            check(aud_fmt, (f < 4) ? f : 0);
        end
        setup(ctl(1'b0, 1'b1, 1'b0, 1'b0, 3'h0), EN_WL);
        check({frame_oe, sel_oe}, 2'b10);
        done("width");
        // slave role: peer pulses counted, fast then slow peer
        for (int i = 0; i < 2; i++) begin
            pl = (i == 0);
            pol_p <= pl;
            gap <= (i == 0) ? 8'd8 : 8'd40;
            setup(ctl(1'b1, pl, 1'b1, 1'b0, 3'h0), EN_WL);
            bus(1'b0, SFS_STATUS_OFS, 32'h0);
            b = rd[7:0];
            d = sent + 8'd4;
            run <= 1'b1;
            k = 0;
            while (sent !== d && k < 1000) begin
                @(negedge sck);
                k++;
            end
            tmo(k, 1000);
            run <= 1'b0;
            // let the last pulse cross back before the count is read
            repeat (4) @(posedge clock);
            bus(1'b0, SFS_STATUS_OFS, 32'h0);
            d = rd[7:0] - b;
            check(d, 4);
            check({frame_oe, sel_oe}, 2'b00);
        end
        done("slave");
        // protected audio bits and qualified effects
        aud = EN_WL | 32'h46;
        setup(ctl(1'b0, 1'b1, 1'b1, 1'b0, 3'h0), aud);
        bus(1'b1, SFS_AUDIO_OFS, EN_WL);
        bus(1'b0, SFS_AUDIO_OFS, 32'h0);
        check(rd, aud);
        check({aud_mono, aud_fmt}, 3'b110);
        bus(1'b1, SFS_AUDIO_OFS, 32'h0);
        for (int u = 0; u < 16; u++) begin
            bus(1'b1, SFS_AUDIO_OFS, {27'h0, u[2], u[1], u[0], u[3], 1'b0});
            repeat (3) @(posedge clock);
            check({aud_mono, urd_tx_en}, {u[0] & u[3], u[1] & u[2]});
        end
        bus(1'b0, SFS_STATUS_OFS, 32'h0);
        check(rd[11:8], 4'he);
        done("audio");
        tally_and_finish;
    end
endmodule // tb_sfs_frame_ctrl
